// File: core/spm_fifo.sv
// show-ahead byte fifo with occupancy count and one-shot clear
// assumes push is dropped when full unless a pop happens in the same cycle, and pop ignored when empty
`timescale 1ns/10ps
`default_nettype none
module spm_fifo #(
  parameter int DEPTH = 64,
  parameter int LW    = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fifo port
  spm_fifo_if.owner f
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [PW-1:0]         wp;
    logic [PW-1:0]         rp;
    logic [LW-1:0]         cnt;
  } spm_fifo_st_t;

  spm_fifo_st_t s_r;
  spm_fifo_st_t s_nxt;
  logic         doPush;
  logic         doPop;

  // pointer and count update
  always_comb begin
    s_nxt  = s_r;
    doPop  = f.pop && (s_r.cnt != '0);
    doPush = f.push && ((s_r.cnt != LW'(DEPTH)) || doPop);
    if (doPush) begin
      s_nxt.mem[s_r.wp] = f.pushData;
      s_nxt.wp          = s_r.wp + PW'(1);
    end
    if (doPop) begin
      s_nxt.rp = s_r.rp + PW'(1);
    end
    s_nxt.cnt = s_r.cnt + LW'(doPush) - LW'(doPop);
    if (f.clr) begin
      s_nxt.wp  = '0;
      s_nxt.rp  = '0;
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // flags from the registered count
  assign f.popData = s_r.mem[s_r.rp];
  assign f.level   = s_r.cnt;
  assign f.full    = (s_r.cnt == LW'(DEPTH));
  assign f.empty   = (s_r.cnt == '0);
endmodule
`default_nettype wire

// File: core/spm_fifo_if.sv
// byte fifo connection between the serial master and one fifo
// assumes the user side drives push/pop and the fifo answers with level and flags
`timescale 1ns/10ps
`default_nettype none
interface spm_fifo_if #(parameter int LW = 7);
  logic          push;
  logic          pop;
  logic          clr;
  logic [7:0]    pushData;
  logic [7:0]    popData;
  logic [LW-1:0] level;
  logic          full;
  logic          empty;
  modport owner (input push, pop, clr, pushData, output popData, level, full, empty);
  modport user  (output push, pop, clr, pushData, input popData, level, full, empty);
endinterface
`default_nettype wire

// File: core/spm_master.sv
// serial master with dma pacing, register access over axi4-lite
// assumes miso is asynchronous; frame end comes from dma logic on clk
// What this block does
// - serial output changes a programmable 1..15 clocks after each shift edge; 0 means 1
// - rx boost high while rx fifo level above rx boost threshold
// - rx dma request high while rx fifo level above rx request threshold
// - rx dma request also high when transfer done and rx fifo not empty
// - tx boost high while tx fifo level at or below tx boost threshold
// - tx dma request high while tx fifo level at or below tx request threshold
// - setting active with empty tx fifo raises done interrupt at once
// - one byte is shifted in for every byte shifted out
// - serial clock toggles only inside a byte; parks when tx empty or rx full
// - auto select asserts at least 3 clocks before first bit
// - auto select releases at least 1 clock after last clock edge
// - dma requests only while dma mode is enabled
// - in dma mode with active clear, fifo write loads length and control
// - frame end pulse clears the transfer active flag
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module spm_master #(
  parameter int DEPTH = 64,
  parameter int LW    = 7
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // serial pins
  output logic             sclk,
  output logic             mosi,
  input  wire logic        miso,
  output logic [2:0]       csLine,
  // dma pacing
  output logic             txDmaReq,
  output logic             txDmaBoost,
  output logic             rxDmaReq,
  output logic             rxDmaBoost,
  input  wire logic        frameEnd,
  // interrupt
  output logic             irq
);
  typedef enum logic {ENG_IDLE, ENG_SHIFT} spm_eng_t;
  typedef struct packed {
    logic [1:0]  csSel;
    logic        clock_edge_phase, clock_rest_level, csPol, ta, dma_mode_enable, completion_irq_enable, rx_need_irq_enable, auto_slave_select;
    logic [15:0] clkDiv, dataLen, byteCnt, divCnt;
    logic [3:0]  holdClocks, edgeCnt, holdCnt;
    logic [31:0] thr;
    spm_eng_t    st;
    logic [7:0]  txSh, rxSh;
    logic        finished, csOn, pendMosi, misoMeta, misoSync;
    logic [1:0]  setupCnt;
    logic        awSeen, wSeen, wrOn, rdOn;
    logic [7:0]  wAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic [1:0]  wrIdx, wrLast, rdIdx, rdLast;
    logic        sclk, mosi, txReq, txBoost, rxReq, rxBoost, irq;
    logic [2:0]  csLine;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
  } spm_st_t;

  spm_st_t s_r;
  spm_st_t s_nxt;
  spm_fifo_if #(.LW(LW)) txf ();
  spm_fifo_if #(.LW(LW)) rx_full_flag ();

  spm_fifo #(.DEPTH(DEPTH), .LW(LW)) u_txf (.clk(clk), .nrst(nrst), .f(txf));
  spm_fifo #(.DEPTH(DEPTH), .LW(LW)) u_rxf (.clk(clk), .nrst(nrst), .f(rx_full_flag));

  logic        done, rxNeed, tick, sampleEdge, hit, wrGo;
  logic [15:0] halfLim;
  logic [3:0]  holdEff;
  logic [7:0]  txLvl, rxLvl;
  logic [31:0] ctrlRd, wMask;

  // low control byte write, shared by the register and the dma header
  function automatic spm_st_t setCtrlLo(spm_st_t x, logic [7:0] b);
    x.csSel = b[1:0];
    x.clock_edge_phase  = b[spm_pkg::CLOCK_EDGE_PHASE_BIT];
    x.clock_rest_level  = b[spm_pkg::CLOCK_REST_LEVEL_BIT];
    x.csPol = b[spm_pkg::CSPOL_BIT];
    x.ta    = b[spm_pkg::TA_BIT];
    return x;
  endfunction

  // status view and helpers
  assign txLvl   = 8'(txf.level);
  assign rxLvl   = 8'(rx_full_flag.level);
  assign done    = s_r.ta && (s_r.st == ENG_IDLE) && txf.empty;
  assign rxNeed  = s_r.ta && (rxLvl >= 8'(spm_pkg::RX_NEED_LVL));
  assign holdEff = (s_r.holdClocks == 4'h0) ? 4'h1 : s_r.holdClocks;
  assign halfLim = (s_r.clkDiv[15:1] == 15'h0) ? 16'h7fff : {1'b0, s_r.clkDiv[15:1]} - 16'h1;
  assign tick    = (s_r.divCnt == halfLim);
  assign sampleEdge = (s_r.edgeCnt[0] == s_r.clock_edge_phase);
  assign wMask   = {{8{s_r.wStrb[3]}}, {8{s_r.wStrb[2]}}, {8{s_r.wStrb[1]}}, {8{s_r.wStrb[0]}}};
  assign wrGo    = s_r.awSeen && s_r.wSeen && !s_r.wrOn && !s_r.bvalid;
  assign hit     = (s_r.wAddr[7:2] == spm_pkg::OFF_FIFO[7:2]);
  always_comb begin
    ctrlRd = '0;
    ctrlRd[1:0] = s_r.csSel;
    ctrlRd[spm_pkg::CLOCK_EDGE_PHASE_BIT]  = s_r.clock_edge_phase;
    ctrlRd[spm_pkg::CLOCK_REST_LEVEL_BIT]  = s_r.clock_rest_level;
    ctrlRd[spm_pkg::CSPOL_BIT] = s_r.csPol;
    ctrlRd[spm_pkg::TA_BIT]    = s_r.ta;
    ctrlRd[spm_pkg::DMA_MODE_ENABLE_BIT] = s_r.dma_mode_enable;
    ctrlRd[spm_pkg::COMPLETION_IRQ_ENABLE_BIT]  = s_r.completion_irq_enable;
    ctrlRd[spm_pkg::RX_NEED_IRQ_ENABLE_BIT]  = s_r.rx_need_irq_enable;
    ctrlRd[spm_pkg::AUTO_SLAVE_SELECT_BIT]  = s_r.auto_slave_select;
    ctrlRd[spm_pkg::DONE_BIT]  = done;
    ctrlRd[spm_pkg::RXD_BIT]   = !rx_full_flag.empty;
    ctrlRd[spm_pkg::TXD_BIT]   = !txf.full;
    ctrlRd[spm_pkg::RXR_BIT]   = rxNeed;
    ctrlRd[spm_pkg::RXF_BIT]   = rx_full_flag.full;
  end

  // next state: bus slave, fifo port, shift engine, pacing outputs
  always_comb begin
    s_nxt = s_r;
    txf.push = 1'b0;
    txf.pushData = s_r.wData[8*s_r.wrIdx +: 8];
    txf.pop = 1'b0;
    txf.clr = 1'b0;
    rx_full_flag.push = 1'b0;
    rx_full_flag.pushData = s_r.clock_edge_phase ? {s_r.rxSh[6:0], s_r.misoSync} : s_r.rxSh;
    rx_full_flag.pop = s_r.rdOn && !rx_full_flag.empty;
    rx_full_flag.clr = 1'b0;
    s_nxt.misoMeta = miso;
    s_nxt.misoSync = s_r.misoMeta;
    // frame end first, so a write in the same cycle wins
    if (frameEnd) s_nxt.ta = 1'b0;
    // write address and data, taken in either order
    if (awvalid && s_r.awready) begin
      s_nxt.awSeen = 1'b1;
      s_nxt.awready = 1'b0;
      s_nxt.wAddr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.wSeen = 1'b1;
      s_nxt.wready = 1'b0;
      s_nxt.wData = wdata;
      s_nxt.wStrb = wstrb;
    end
    if (wrGo) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = spm_pkg::RESP_OKAY;
      case (s_r.wAddr[7:2])
        spm_pkg::OFF_CTRL[7:2]: begin
          if (s_r.wStrb[0]) begin
            s_nxt = setCtrlLo(s_nxt, s_r.wData[7:0]);
            txf.clr = s_r.wData[spm_pkg::CLRTX_BIT];
            rx_full_flag.clr = s_r.wData[spm_pkg::CLRRX_BIT];
          end
          if (s_r.wStrb[1]) begin
            s_nxt.dma_mode_enable = s_r.wData[spm_pkg::DMA_MODE_ENABLE_BIT];
            s_nxt.completion_irq_enable  = s_r.wData[spm_pkg::COMPLETION_IRQ_ENABLE_BIT];
            s_nxt.rx_need_irq_enable  = s_r.wData[spm_pkg::RX_NEED_IRQ_ENABLE_BIT];
            s_nxt.auto_slave_select  = s_r.wData[spm_pkg::AUTO_SLAVE_SELECT_BIT];
          end
        end
        spm_pkg::OFF_FIFO[7:2]: begin
          if (s_r.ta) begin
            // bytes go in low lane first; four per word in dma mode
            s_nxt.bvalid = 1'b0;
            s_nxt.wrOn = 1'b1;
            s_nxt.wrIdx = 2'h0;
            s_nxt.wrLast = s_r.dma_mode_enable ? 2'h3 : 2'h0;
          end else if (s_r.dma_mode_enable) begin
            s_nxt.dataLen = s_r.wData[31:16];
            s_nxt = setCtrlLo(s_nxt, s_r.wData[7:0]);
            txf.clr = s_r.wData[spm_pkg::CLRTX_BIT];
            rx_full_flag.clr = s_r.wData[spm_pkg::CLRRX_BIT];
          end
        end
        spm_pkg::OFF_CLKDIV[7:2]: s_nxt.clkDiv = (s_r.clkDiv & ~wMask[15:0]) | (s_r.wData[15:0] & wMask[15:0]);
        spm_pkg::OFF_DLEN[7:2]: s_nxt.dataLen = (s_r.dataLen & ~wMask[15:0]) | (s_r.wData[15:0] & wMask[15:0]);
        spm_pkg::OFF_HOLD[7:2]: if (s_r.wStrb[0]) s_nxt.holdClocks = s_r.wData[3:0];
        spm_pkg::OFF_THR[7:2]: s_nxt.thr = (s_r.thr & ~wMask) | (s_r.wData & wMask);
        default: s_nxt.bresp = spm_pkg::RESP_SLVERR;
      endcase
    end
    // unpack a fifo write; bytes meeting a full fifo are dropped
    if (s_r.wrOn) begin
      txf.push = !txf.full;
      s_nxt.wrIdx = s_r.wrIdx + 2'h1;
      if (s_r.wrIdx == s_r.wrLast) begin
        s_nxt.wrOn = 1'b0;
        s_nxt.bvalid = 1'b1;
      end
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awSeen = 1'b0;
      s_nxt.wSeen = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end
    // read channel
    if (arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rresp = spm_pkg::RESP_OKAY;
      s_nxt.rvalid = 1'b1;
      case (araddr[7:2])
        spm_pkg::OFF_CTRL[7:2]: s_nxt.rdata = ctrlRd;
        spm_pkg::OFF_FIFO[7:2]: begin
          s_nxt.rdata = '0;
          s_nxt.rvalid = 1'b0;
          s_nxt.rdOn = 1'b1;
          s_nxt.rdIdx = 2'h0;
          s_nxt.rdLast = (s_r.dma_mode_enable && s_r.ta) ? 2'h3 : 2'h0;
        end
        spm_pkg::OFF_CLKDIV[7:2]: s_nxt.rdata = {16'h0, s_r.clkDiv};
        spm_pkg::OFF_DLEN[7:2]: s_nxt.rdata = {16'h0, s_r.dataLen};
        spm_pkg::OFF_HOLD[7:2]: s_nxt.rdata = {28'h0, s_r.holdClocks};
        spm_pkg::OFF_THR[7:2]: s_nxt.rdata = s_r.thr;
        default: begin
          s_nxt.rdata = '0;
          s_nxt.rresp = spm_pkg::RESP_SLVERR;
        end
      endcase
    end
    // gather rx bytes into the read word; an empty fifo leaves zero
    if (s_r.rdOn) begin
      if (!rx_full_flag.empty) s_nxt.rdata[8*s_r.rdIdx +: 8] = rx_full_flag.popData;
      s_nxt.rdIdx = s_r.rdIdx + 2'h1;
      if (s_r.rdIdx == s_r.rdLast) begin
        s_nxt.rdOn = 1'b0;
        s_nxt.rvalid = 1'b1;
      end
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end
    // output hold: the pin follows the pending bit after holdEff clocks
    if (s_r.holdCnt != 4'h0) begin
      s_nxt.holdCnt = s_r.holdCnt - 4'h1;
      if (s_r.holdCnt == 4'h1) s_nxt.mosi = s_r.pendMosi;
    end
    // shift engine
    case (s_r.st)
      ENG_IDLE: begin
        s_nxt.sclk = s_r.clock_rest_level;
        if (s_r.ta && s_r.csOn && (s_r.setupCnt == 2'h0) && !txf.empty && !rx_full_flag.full
            && !s_r.finished) begin
          txf.pop = 1'b1;
          s_nxt.txSh = txf.popData;
          s_nxt.edgeCnt = 4'h0;
          s_nxt.divCnt = 16'h0;
          s_nxt.st = ENG_SHIFT;
          if (!s_r.clock_edge_phase) begin
            s_nxt.pendMosi = txf.popData[7];
            s_nxt.holdCnt = holdEff;
          end
        end
      end
      ENG_SHIFT: begin
        s_nxt.divCnt = s_r.divCnt + 16'h1;
        if (tick) begin
          s_nxt.divCnt = 16'h0;
          s_nxt.sclk = !s_r.sclk;
          s_nxt.edgeCnt = s_r.edgeCnt + 4'h1;
          if (sampleEdge) begin
            s_nxt.rxSh = {s_r.rxSh[6:0], s_r.misoSync};
          end else if (s_r.clock_edge_phase) begin
            s_nxt.pendMosi = s_r.txSh[7];
            s_nxt.txSh = {s_r.txSh[6:0], 1'b0};
            s_nxt.holdCnt = holdEff;
          end else if (s_r.edgeCnt != 4'hf) begin
            s_nxt.pendMosi = s_r.txSh[6];
            s_nxt.txSh = {s_r.txSh[6:0], 1'b0};
            s_nxt.holdCnt = holdEff;
          end
          if (s_r.edgeCnt == 4'hf) begin
            rx_full_flag.push = 1'b1;
            s_nxt.st = ENG_IDLE;
            s_nxt.byteCnt = s_r.byteCnt + 16'h1;
            if (s_r.dma_mode_enable && (s_r.byteCnt + 16'h1 == s_r.dataLen)) s_nxt.finished = 1'b1;
          end
        end
      end
      default: s_nxt.st = ENG_IDLE;
    endcase
    if (!s_r.ta) begin
      s_nxt.byteCnt = 16'h0;
      s_nxt.finished = 1'b0;
    end
    // select lines with setup count on assertion
    s_nxt.csOn = s_nxt.ta && !(s_r.dma_mode_enable && s_r.auto_slave_select && s_r.finished && s_r.st == ENG_IDLE);
    if (s_nxt.csOn && !s_r.csOn) s_nxt.setupCnt = spm_pkg::CS_SETUP_CLKS;
    else if (s_r.setupCnt != 2'h0) s_nxt.setupCnt = s_r.setupCnt - 2'h1;
    for (int i = 0; i < 3; i++) begin
      s_nxt.csLine[i] = (s_nxt.csOn && s_nxt.csSel == 2'(i)) ~^ s_nxt.csPol;
    end
    // pacing levels, recomputed every clock
    s_nxt.txReq   = s_r.dma_mode_enable && (txLvl <= s_r.thr[spm_pkg::TXREQ_LSB +: 8]);
    s_nxt.txBoost = s_r.dma_mode_enable && (txLvl <= s_r.thr[spm_pkg::TXBOOST_LSB +: 8]);
    s_nxt.rxReq   = s_r.dma_mode_enable && ((rxLvl > s_r.thr[spm_pkg::RXREQ_LSB +: 8])
                    || (done && !rx_full_flag.empty));
    s_nxt.rxBoost = s_r.dma_mode_enable && (rxLvl > s_r.thr[spm_pkg::RXBOOST_LSB +: 8]);
    s_nxt.irq     = (s_r.completion_irq_enable && done) || (s_r.rx_need_irq_enable && rxNeed);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.holdClocks <= spm_pkg::HOLD_RST;
      s_r.thr <= spm_pkg::THR_RST;
      s_r.csLine <= 3'h7;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ports straight from the state register
  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rresp = s_r.rresp;
  assign rdata = s_r.rdata;
  assign sclk = s_r.sclk;
  assign mosi = s_r.mosi;
  assign csLine = s_r.csLine;
  assign txDmaReq = s_r.txReq;
  assign txDmaBoost = s_r.txBoost;
  assign rxDmaReq = s_r.rxReq;
  assign rxDmaBoost = s_r.rxBoost;
  assign irq = s_r.irq;

  // helper counter for the select setup check
  logic [7:0] csAge;
  always_ff @(posedge clk) begin
    if (!nrst || !s_r.csOn) csAge <= 8'h0;
    else if (csAge != 8'hff) csAge <= csAge + 8'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_hold_delay: assert property ($changed(s_r.mosi) |-> s_r.holdCnt == 4'h0 && $past(s_r.holdCnt) == 4'h1) else $error("mosi changed outside hold expiry");
  a_rx_boost: assert property (s_r.dma_mode_enable && rxLvl > s_r.thr[31:24] |=> rxDmaBoost) else $error("rx boost missing");
  a_rx_req: assert property (s_r.dma_mode_enable && rxLvl > s_r.thr[23:16] |=> rxDmaReq) else $error("rx request missing");
  a_rx_tail: assert property (s_r.dma_mode_enable && done && !rx_full_flag.empty |=> rxDmaReq) else $error("rx tail request missing");
  a_tx_boost: assert property (s_r.dma_mode_enable && txLvl <= s_r.thr[15:8] |=> txDmaBoost) else $error("tx boost missing");
  a_tx_req: assert property (txDmaReq == ($past(s_r.dma_mode_enable) && $past(txLvl) <= $past(s_r.thr[7:0])))
    else $error("tx request wrong");
  a_done_irq: assert property ($rose(s_r.ta) && s_r.completion_irq_enable && txf.empty && s_r.st == ENG_IDLE |=> irq) else $error("done irq missing");
  a_byte_pair: assert property (rx_full_flag.push |-> txf.pop == 1'b0 && s_r.st == ENG_SHIFT && s_r.edgeCnt == 4'hf) else $error("rx byte not paired");
  a_sclk_park: assert property (s_r.st == ENG_IDLE ##1 s_r.st == ENG_IDLE |-> sclk == $past(s_r.clock_rest_level)) else $error("clock not parked");
  a_cs_setup: assert property ($rose(s_r.st == ENG_SHIFT) |-> csAge >= 8'h3) else $error("select setup short");
  a_cs_release: assert property ($fell(s_r.csOn) && s_r.ta |-> $past(s_r.st) == ENG_IDLE) else $error("select released early");
  a_req_gate: assert property (!s_r.dma_mode_enable |=> !txDmaReq && !rxDmaReq) else $error("request without dma mode");
  a_hdr_load: assert property (wrGo && hit && !s_r.ta && s_r.dma_mode_enable |=> s_r.dataLen == $past(s_r.wData[31:16])) else $error("header not loaded");
  a_frame_end: assert property (frameEnd && !wrGo |=> !s_r.ta) else $error("frame end ignored");
  c_byte_done: cover property (rx_full_flag.push);
  c_dma_header: cover property (wrGo && hit && !s_r.ta && s_r.dma_mode_enable);
  c_dma_finish: cover property ($rose(s_r.finished));
  c_rx_boost: cover property (rxDmaBoost);
endmodule
`default_nettype wire

// File: core/spm_pkg.sv
// constants for the serial master: register map, field positions, reset values, timing
// assumes a 32-bit register bus with byte addresses and a 64-entry byte fifo each way
package spm_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_FIFO   = 8'h04;
  localparam logic [7:0] OFF_CLKDIV = 8'h08;
  localparam logic [7:0] OFF_DLEN   = 8'h0c;
  localparam logic [7:0] OFF_HOLD   = 8'h10;
  localparam logic [7:0] OFF_THR    = 8'h14;
  // control/status field positions
  localparam int CLOCK_EDGE_PHASE_BIT  = 2;
  localparam int CLOCK_REST_LEVEL_BIT  = 3;
  localparam int CLRTX_BIT = 4;
  localparam int CLRRX_BIT = 5;
  localparam int CSPOL_BIT = 6;
  localparam int TA_BIT    = 7;
  localparam int DMA_MODE_ENABLE_BIT = 8;
  localparam int COMPLETION_IRQ_ENABLE_BIT  = 9;
  localparam int RX_NEED_IRQ_ENABLE_BIT  = 10;
  localparam int AUTO_SLAVE_SELECT_BIT  = 11;
  localparam int DONE_BIT  = 16;
  localparam int RXD_BIT   = 17;
  localparam int TXD_BIT   = 18;
  localparam int RXR_BIT   = 19;
  localparam int RXF_BIT   = 20;
  // threshold field positions (low bit of each byte)
  localparam int RXBOOST_LSB = 24;
  localparam int RXREQ_LSB   = 16;
  localparam int TXBOOST_LSB = 8;
  localparam int TXREQ_LSB   = 0;
  // reset values
  localparam logic [3:0]  HOLD_RST = 4'h1;
  localparam logic [31:0] THR_RST  = 32'h3020_1020;
  // timing and levels
  localparam logic [1:0] CS_SETUP_CLKS = 2'h3;
  localparam int         RX_NEED_LVL   = 48;
  localparam int         FIFO_DEPTH    = 64;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage

// File: tb/spm_slave_model.sv
// serial slave model on select 0: mode 0, takes in mosi, answers a fixed byte in every byte slot
// assumes the clock rests low between frames and select is active low
`timescale 1ns/10ps
`default_nettype none
module spm_slave_model #(
  parameter logic [7:0] REPLY = 8'h3c
) (
  // serial pins
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic [2:0] csLine,
  output logic            miso,
  // last byte taken in
  output logic [7:0]      got
);
  logic [7:0] sh;
  logic [3:0] bits;
  // idle values
  initial begin
    miso = 1'b0;
    got  = 8'h00;
    sh   = REPLY;
    bits = 4'h0;
  end
  // frame start puts the first answer bit out
  always @(negedge csLine[0]) begin
    sh   = REPLY;
    bits = 4'h0;
    miso = REPLY[7];
  end
  // sample on the rising edge, one bit in per bit out
  always @(posedge sclk) begin
    if (!csLine[0]) begin
      got  = {got[6:0], mosi};
      bits = bits + 4'h1;
    end
  end
  // next answer bit on the falling edge; a full byte reloads the answer
  always @(negedge sclk) begin
    if (!csLine[0]) begin
      if (bits == 4'h8) begin
        sh   = REPLY;
        bits = 4'h0;
      end else begin
        sh   = {sh[6:0], 1'b0};
      end
      miso = sh[7];
    end
  end
  // released line shows the inverse, never a held value
  always @(posedge csLine[0]) miso = ~miso;
endmodule
`default_nettype wire

// File: tb/tb_spm_master.sv
// testbench for the serial master: register bus tasks, poll transfer, dma pacing
// assumes the slave model answers 8'h3c on select 0
`timescale 1ns/10ps
`default_nettype none
module tb_spm_master;
  // bench signals
  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready, miso, frameEnd;
  logic        awready, wready, bvalid, arready, rvalid, sclk, mosi, irq;
  logic        txDmaReq, txDmaBoost, rxDmaReq, rxDmaBoost;
  logic [7:0]  awaddr, araddr, slvGot;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr;
  logic [2:0]  csLine;
  int          errors, cmp_count, n;
  // design and far side
  spm_master dut_u (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .sclk, .mosi, .miso, .csLine, .txDmaReq, .txDmaBoost,
    .rxDmaReq, .rxDmaBoost, .frameEnd, .irq);
  spm_slave_model slv_u (.sclk, .mosi, .csLine, .miso, .got(slvGot));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      t++;
    end while (!bvalid && t < 200);
    bready <= 1'b0;
    if (t >= 200) errors++;
  endtask
  // axi4-lite read into rd and rr
  task automatic rdw(input logic [7:0] a);
    int t;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      t++;
    end while (!rvalid && t < 200);
    rd = rdata; rr = rresp;
    rready <= 1'b0;
    if (t >= 200) errors++;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rdw(a);
    chk(rd & m, e);
  endtask
  // poll the done flag, bounded
  task automatic waitDone();
    int k;
    k = 0;
    do begin
      rdw(spm_pkg::OFF_CTRL);
      k++;
    end while (rd[16] !== 1'b1 && k < 1000);
    chk(rd[16], 32'h1);
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test();
  end
  // test sequence
  initial begin
    nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; frameEnd = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    wstrb = 4'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdChk(spm_pkg::OFF_HOLD, 32'h0000_000f, 32'h0000_0001);
    rdChk(spm_pkg::OFF_THR, 32'hffff_ffff, 32'h3020_1020);
    rdw(8'h1c);
    chk(rr, 32'h2);
    // poll transfer with done interrupt, select under software control; 200 ns link clock
    wr(spm_pkg::OFF_CLKDIV, 32'h8);
    wr(spm_pkg::OFF_CTRL, 32'h280);
    repeat (3) @(posedge clk);
    chk(irq, 32'h1);
    wr(spm_pkg::OFF_FIFO, 32'ha5);
    waitDone();
    chk(slvGot, 32'ha5);
    chk(sclk, 32'h0);
    // dma pacing from fifo levels
    wr(spm_pkg::OFF_CTRL, 32'h0);
    wr(spm_pkg::OFF_THR, 32'h0000_1020);
    wr(spm_pkg::OFF_CTRL, 32'h100);
    repeat (3) @(posedge clk);
    chk({rxDmaBoost, rxDmaReq, txDmaBoost, txDmaReq}, 32'hf);
    wr(spm_pkg::OFF_THR, 32'h0101_0000);
    repeat (3) @(posedge clk);
    chk({rxDmaBoost, rxDmaReq, txDmaBoost, txDmaReq}, 32'h3);
    wr(spm_pkg::OFF_CTRL, 32'h180);
    repeat (3) @(posedge clk);
    chk(rxDmaReq, 32'h1);
    @(posedge clk) frameEnd <= 1'b1;
    @(posedge clk) frameEnd <= 1'b0;
    rdChk(spm_pkg::OFF_CTRL, 32'h80, 32'h0);
    wr(spm_pkg::OFF_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk({rxDmaBoost, rxDmaReq, txDmaBoost, txDmaReq}, 32'h0);
    // received byte read back in poll mode
    wr(spm_pkg::OFF_CTRL, 32'h80);
    rdChk(spm_pkg::OFF_FIFO, 32'hff, 32'h3c);
    // interrupt transfer: 64 bytes out, 48 read on the rx interrupt, then drain
    wr(spm_pkg::OFF_CTRL, 32'h680);
    for (int i = 0; i < 64; i++) wr(spm_pkg::OFF_FIFO, 32'(i));
    do @(posedge clk); while (irq !== 1'b1);
    rdChk(spm_pkg::OFF_CTRL, 32'h0008_0000, 32'h0008_0000);
    for (int i = 0; i < 48; i++) rdChk(spm_pkg::OFF_FIFO, 32'hff, 32'h3c);
    waitDone();
    wr(spm_pkg::OFF_CTRL, 32'h600);
    n = 0;
    rdw(spm_pkg::OFF_CTRL);
    while (rd[17] === 1'b1 && n < 64) begin
      rdChk(spm_pkg::OFF_FIFO, 32'hff, 32'h3c);
      rdw(spm_pkg::OFF_CTRL);
      n++;
    end
    chk(n, 32'h10);
    chk(slvGot, 32'h3f);
    // dma stream with auto select: header word, then one data word of four bytes
    wr(spm_pkg::OFF_CTRL, 32'h900);
    wr(spm_pkg::OFF_FIFO, 32'h0004_00b0);
    rdChk(spm_pkg::OFF_DLEN, 32'hffff, 32'h4);
    wr(spm_pkg::OFF_FIFO, 32'h4433_2211);
    waitDone();
    chk(csLine, 32'h7);
    chk(slvGot, 32'h44);
    rdChk(spm_pkg::OFF_FIFO, 32'hffff_ffff, 32'h3c3c_3c3c);
    wr(spm_pkg::OFF_CTRL, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
